// ==== adc_mode_clock_config_regs.sv ====
// Mode and clock configuration registers with ready pin and word formatter
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/10ps
// Behaviour
// - Register-map check tracking runs only while mode bit 13 is set.
// - Incoming frame check runs only while mode bit 12 is set.
// - Mode bit 11 picks CCITT (0, reset) or ANSI (1) polynomial.
// - Mode bit 10 resets to 1; writing 0 clears the reset indication.
// - Mode bits 9:8 set word length; 00b 16 bits, 01b 24 bits default.
// - 32-bit words: 10b pads low byte zero, 11b sign-extends top byte.
// - Mode bit 4 enables serial timeout; resets to 1.
// - Ready source 00b follows most lagging channel, 01b ORs enabled ones.
// - Ready source 10b and 11b follow the most leading enabled channel.
// - Idle ready pin drives high if mode bit 1 is 0, floats if 1.
// - With data, ready holds low if mode bit 0 is 0, pulses if 1.
// - Clock bits 13..8 enable channels 5..0; all reset to 1.
// - Clock bit 7 set disables the crystal oscillator; resets to 0.
// - Clock bit 6 set selects external reference; resets to 0.
// - Clock bits 4:2 give oversampling 128 shl code; reset code 011b.
// - Clock bits 1:0 power: 00b very low, 01b low, 1xb high-res.
// - Clock register at address 03h, reset value 7F0Eh.
// - Mode register at address 02h, reset value 0510h.
module adc_mode_clock_config_regs
  import adc_cfg_pkg::*;
#(
  parameter int CHANNELS     = NUM_CHANNELS,
  parameter int PULSE_CYCLES = READY_PULSE_CYCLES
)
(
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic [7:0]          reg_addr,
  input  wire logic [15:0]         reg_wdata,
  input  wire logic                reg_write,
  input  wire logic                reg_read,
  output logic      [15:0]         reg_rdata,
  input  wire logic [CHANNELS-1:0] channel_data_ready,
  input  wire logic                conversion_consumed,
  input  wire logic                status_reset_clear_ack,
  input  wire logic [23:0]         sample_in,
  output logic      [31:0]         sample_word,
  output logic      [5:0]          sample_bits,
  output logic                     status_reset_flag,
  output config_out_t              config_out,
  output logic                     reg_check_active,
  output logic                     input_check_active,
  output logic                     conversion_ready_pin_out,
  output logic                     conversion_ready_pin_oe
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [2:0] {
    PIN_IDLE  = 3'h1,
    PIN_PULSE = 3'h2,
    PIN_HOLD  = 3'h4
  } pin_state_t;

  typedef struct packed {
    logic [15:0]         mode_reg;
    logic [15:0]         clock_reg;
    logic [15:0]         rdata;
    logic                status_reset;
    pin_state_t          pin_state;
    logic [7:0]          pulse_count;
    logic [CHANNELS-1:0] seen;
    logic [31:0]         word;
    logic [5:0]          bits;
  } state_t;

  state_t state;
  state_t next_state;
  reg_req_t req;
  logic [CHANNELS-1:0] enabled;
  logic                any_ready;
  logic                all_ready;
  logic                source_event;
  ready_pin_t          pin;

  // Masks a value to its writable bits
  function automatic logic [15:0] masked(input logic [15:0] value,
                                         input logic [15:0] mask);
    masked = value & mask;
  endfunction

  assign req = '{addr: reg_addr, wdata: reg_wdata,
                 write: reg_write, read: reg_read};
  assign enabled = state.clock_reg[CLOCK_CHAN_EN_LSB +: CHANNELS];

  // ----------------------------------------
  // Ready source selection
  // ----------------------------------------
  always_comb
  begin
    any_ready = |(channel_data_ready & enabled);
    // Lagging: fires once every enabled channel has reported this round
    all_ready = (enabled != '0) &&
                (((state.seen | channel_data_ready) & enabled) == enabled);
    unique case (ready_source_t'(state.mode_reg[MODE_READY_SRC_LSB +: 2]))
      READY_LAGGING:   source_event = all_ready;
      READY_OR:        source_event = any_ready;
      READY_LEADING_A,
      READY_LEADING_B: source_event = any_ready &&
                                      ((state.seen & enabled) == '0);
    endcase
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    next_state = state;
    next_state.rdata = '0;

    // Register writes
    if (req.write)
    begin
      if (req.addr == OPERATING_MODE_CONFIG_ADDR)
      begin
        next_state.mode_reg = masked(req.wdata, MODE_WRITE_MASK);
        // Only a written 0 clears; writing 1 keeps the indication
        next_state.mode_reg[MODE_RESET_FLAG_BIT] =
          state.mode_reg[MODE_RESET_FLAG_BIT] &
          req.wdata[MODE_RESET_FLAG_BIT];
        if (!req.wdata[MODE_RESET_FLAG_BIT])
          next_state.status_reset = 1'b0;
      end
      if (req.addr == CLOCK_AND_CHANNEL_CONFIG_ADDR)
        next_state.clock_reg = masked(req.wdata, CLOCK_WRITE_MASK);
    end

    // Register reads, data in the following cycle
    if (req.read)
    begin
      unique case (req.addr)
        OPERATING_MODE_CONFIG_ADDR:    next_state.rdata = state.mode_reg;
        CLOCK_AND_CHANNEL_CONFIG_ADDR: next_state.rdata = state.clock_reg;
        default:                       next_state.rdata = '0;
      endcase
    end

    // Per-channel tracking for lagging and leading selection
    // A round closes once every enabled channel has reported, so leading
    // mode signals only the first channel of each round
    if (all_ready)
      next_state.seen = '0;
    else
      next_state.seen = (state.seen | channel_data_ready) & enabled;

    // Ready pin sequencing
    unique case (state.pin_state)
      PIN_IDLE:
        if (source_event)
        begin
          if (state.mode_reg[MODE_READY_PULSE_BIT])
          begin
            next_state.pin_state   = PIN_PULSE;
            next_state.pulse_count = 8'(PULSE_CYCLES - 1);
          end
          else
            next_state.pin_state = PIN_HOLD;
        end
      PIN_PULSE:
        if (state.pulse_count == '0)
          next_state.pin_state = PIN_IDLE;
        else
          next_state.pulse_count = state.pulse_count - 8'h01;
      PIN_HOLD:
        // Held low until the host takes the data
        if (conversion_consumed)
          next_state.pin_state = PIN_IDLE;
      default:
        next_state.pin_state = PIN_IDLE;
    endcase

    // Output word formatting
    unique case (word_length_t'(state.mode_reg[MODE_WORD_LEN_LSB +: 2]))
      WORD_16:
      begin
        next_state.word = {16'h0000, sample_in[23:8]};
        next_state.bits = 6'h10;
      end
      WORD_24:
      begin
        next_state.word = {8'h00, sample_in};
        next_state.bits = 6'h18;
      end
      WORD_32_ZERO:
      begin
        next_state.word = {sample_in, 8'h00};
        next_state.bits = 6'h20;
      end
      WORD_32_SIGN:
      begin
        next_state.word = {{8{sample_in[23]}}, sample_in};
        next_state.bits = 6'h20;
      end
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state.mode_reg     <= OPERATING_MODE_CONFIG_RESET;
      state.clock_reg    <= CLOCK_AND_CHANNEL_CONFIG_RESET;
      state.rdata        <= 16'h0000;
      state.status_reset <= 1'b1;
      state.pin_state    <= PIN_IDLE;
      state.pulse_count  <= 8'h00;
      state.seen         <= '0;
      state.word         <= 32'h0000_0000;
      state.bits         <= 6'h18;
    end
    else
      state <= next_state;
  end

  // ----------------------------------------
  // Ready pin drive
  // ----------------------------------------
  always_comb
  begin
    if (state.pin_state == PIN_IDLE)
    begin
      // Idle: high, or released so several devices can share the line
      pin.value = 1'b1;
      pin.drive = ~state.mode_reg[MODE_READY_FLOAT_BIT];
    end
    else
    begin
      pin.value = 1'b0;
      pin.drive = 1'b1;
    end
  end

  assign conversion_ready_pin_out = pin.value;
  assign conversion_ready_pin_oe  = pin.drive;

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign reg_rdata          = state.rdata;
  assign sample_word        = state.word;
  assign sample_bits        = state.bits;
  assign status_reset_flag  = state.status_reset;
  assign reg_check_active   = state.mode_reg[MODE_REG_CHECK_BIT];
  assign input_check_active = state.mode_reg[MODE_INPUT_CHECK_BIT];

  always_comb
  begin
    config_out.reg_check_enable   = state.mode_reg[MODE_REG_CHECK_BIT];
    config_out.input_check_enable = state.mode_reg[MODE_INPUT_CHECK_BIT];
    config_out.poly_ansi          = state.mode_reg[MODE_POLY_BIT];
    config_out.reset_flag         = state.mode_reg[MODE_RESET_FLAG_BIT];
    config_out.word_length_select =
      word_length_t'(state.mode_reg[MODE_WORD_LEN_LSB +: 2]);
    config_out.timeout_enable     = state.mode_reg[MODE_TIMEOUT_BIT];
    config_out.channel_conv_enable = enabled;
    config_out.oscillator_disable =
      state.clock_reg[CLOCK_OSC_DIS_BIT];
    config_out.external_vref_enable =
      state.clock_reg[CLOCK_EXT_VREF_BIT];
    config_out.oversample_select  = state.clock_reg[CLOCK_OSR_LSB +: 3];
    config_out.oversample_ratio   = 15'(OSR_BASE_RATIO)
      << state.clock_reg[CLOCK_OSR_LSB +: 3];
    config_out.power_mode_select  =
      power_mode_t'(state.clock_reg[CLOCK_POWER_LSB +: 2]);
  end

endmodule

// ==== adc_cfg_pkg.sv ====
// Package: register map, field positions, reset values and types
package adc_cfg_pkg;

  localparam int NUM_CHANNELS = 6;

  // ----------------------------------------
  // Register addresses and reset values
  // ----------------------------------------
  localparam logic [7:0]  OPERATING_MODE_CONFIG_ADDR    = 8'h02;
  localparam logic [7:0]  CLOCK_AND_CHANNEL_CONFIG_ADDR = 8'h03;
  localparam logic [15:0] OPERATING_MODE_CONFIG_RESET    = 16'h0510;
  localparam logic [15:0] CLOCK_AND_CHANNEL_CONFIG_RESET = 16'h7F0E;

  // Writable bits; writes clear the reserved ones, but clock bit 14 resets to 1
  localparam logic [15:0] MODE_WRITE_MASK  = 16'h3F1F;
  localparam logic [15:0] CLOCK_WRITE_MASK = 16'h3FDF;

  // ----------------------------------------
  // Mode register field positions
  // ----------------------------------------
  localparam int MODE_REG_CHECK_BIT    = 13;
  localparam int MODE_INPUT_CHECK_BIT  = 12;
  localparam int MODE_POLY_BIT         = 11;
  localparam int MODE_RESET_FLAG_BIT   = 10;
  localparam int MODE_WORD_LEN_LSB     = 8;
  localparam int MODE_TIMEOUT_BIT      = 4;
  localparam int MODE_READY_SRC_LSB    = 2;
  localparam int MODE_READY_FLOAT_BIT  = 1;
  localparam int MODE_READY_PULSE_BIT  = 0;

  // ----------------------------------------
  // Clock register field positions
  // ----------------------------------------
  localparam int CLOCK_CHAN_EN_LSB     = 8;
  localparam int CLOCK_OSC_DIS_BIT     = 7;
  localparam int CLOCK_EXT_VREF_BIT    = 6;
  localparam int CLOCK_OSR_LSB         = 2;
  localparam int CLOCK_POWER_LSB       = 0;

  // Base oversampling ratio at code 000b
  localparam int OSR_BASE_RATIO        = 128;

  // Length of the ready low pulse, in clock cycles
  localparam int READY_PULSE_CYCLES    = 4;

  // ----------------------------------------
  // Encodings
  // ----------------------------------------
  typedef enum logic [1:0] {
    WORD_16         = 2'h0,
    WORD_24         = 2'h1,
    WORD_32_ZERO    = 2'h2,
    WORD_32_SIGN    = 2'h3
  } word_length_t;

  typedef enum logic [1:0] {
    READY_LAGGING   = 2'h0,
    READY_OR        = 2'h1,
    READY_LEADING_A = 2'h2,
    READY_LEADING_B = 2'h3
  } ready_source_t;

  typedef enum logic [1:0] {
    POWER_VERY_LOW  = 2'h0,
    POWER_LOW       = 2'h1,
    POWER_HIGH_RES  = 2'h2,
    POWER_HIGH_RES2 = 2'h3
  } power_mode_t;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        write;
    logic        read;
  } reg_req_t;

  typedef struct packed {
    logic          reg_check_enable;
    logic          input_check_enable;
    logic          poly_ansi;
    logic          reset_flag;
    word_length_t  word_length_select;
    logic          timeout_enable;
    logic [NUM_CHANNELS-1:0] channel_conv_enable;
    logic          oscillator_disable;
    logic          external_vref_enable;
    logic [2:0]    oversample_select;
    logic [14:0]   oversample_ratio;
    power_mode_t   power_mode_select;
  } config_out_t;

  typedef struct packed {
    logic drive;
    logic value;
  } ready_pin_t;

endpackage

// ==== cfg_regs_assertions.sv ====
// Checker for the mode and clock configuration register block
`timescale 1ns/10ps
module cfg_regs_checker
  import adc_cfg_pkg::*;
#(
  parameter int CHANNELS     = NUM_CHANNELS,
  parameter int PULSE_CYCLES = READY_PULSE_CYCLES
)
(
  input wire logic                clk,
  input wire logic                sys_rst,
  input wire logic [7:0]          reg_addr,
  input wire logic [15:0]         reg_wdata,
  input wire logic                reg_write,
  input wire logic                reg_read,
  input wire logic [15:0]         reg_rdata,
  input wire logic [CHANNELS-1:0] channel_data_ready,
  input wire logic                conversion_consumed,
  input wire logic                status_reset_clear_ack,
  input wire logic [23:0]         sample_in,
  input wire logic [31:0]         sample_word,
  input wire logic [5:0]          sample_bits,
  input wire logic                status_reset_flag,
  input wire config_out_t         config_out,
  input wire logic                reg_check_active,
  input wire logic                input_check_active,
  input wire logic                conversion_ready_pin_out,
  input wire logic                conversion_ready_pin_oe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  logic mode_wr;
  logic clk_wr;
  assign mode_wr = reg_write && reg_addr == OPERATING_MODE_CONFIG_ADDR;
  assign clk_wr  = reg_write && reg_addr == CLOCK_AND_CHANNEL_CONFIG_ADDR;

  reg_check_a: assert property (
    mode_wr |=> reg_check_active == $past(reg_wdata[13]))
    else $error("register check enable wrong");
  input_check_a: assert property (
    mode_wr |=> input_check_active == $past(reg_wdata[12]))
    else $error("input check enable wrong");
  poly_select_a: assert property (
    mode_wr |=> config_out.poly_ansi == $past(reg_wdata[11]))
    else $error("polynomial select wrong");
  reset_clear_a: assert property (
    mode_wr && !reg_wdata[10] |=> !status_reset_flag)
    else $error("reset indication not cleared");
  word_len_a: assert property (sample_bits == (
    $past(config_out.word_length_select) == WORD_16 ? 6'h10 :
    $past(config_out.word_length_select) == WORD_24 ? 6'h18 : 6'h20))
    else $error("word length wrong");
  pad_zero_a: assert property (
    $past(config_out.word_length_select) == WORD_32_ZERO
    |-> sample_word == {$past(sample_in), 8'h00})
    else $error("zero padding wrong");
  float_idle_a: assert property (
    !conversion_ready_pin_oe |-> conversion_ready_pin_out)
    else $error("pin floats while active");
  chan_enable_a: assert property (
    clk_wr |=> config_out.channel_conv_enable == $past(reg_wdata[13:8]))
    else $error("channel enables wrong");
  osc_vref_a: assert property (clk_wr |=>
    {config_out.oscillator_disable, config_out.external_vref_enable}
    == $past(reg_wdata[7:6]))
    else $error("oscillator or reference select wrong");
  osr_ratio_a: assert property (
    config_out.oversample_ratio == 15'h0080 << config_out.oversample_select)
    else $error("oversampling ratio wrong");
  unmapped_write_a: assert property (
    reg_write && !mode_wr && !clk_wr |=> $stable(config_out))
    else $error("unmapped write changed registers");
  timeout_en_a: assert property (
    mode_wr |=> config_out.timeout_enable == $past(reg_wdata[4]))
    else $error("timeout enable wrong");
  power_mode_a: assert property (
    clk_wr |=> config_out.power_mode_select == $past(reg_wdata[1:0]))
    else $error("power mode wrong");

  cover property (mode_wr);
  cover property (clk_wr);
  cover property ($fell(conversion_ready_pin_out));
endmodule

bind adc_mode_clock_config_regs cfg_regs_checker #(
  .CHANNELS(CHANNELS), .PULSE_CYCLES(PULSE_CYCLES)) chk (.clk, .sys_rst,
  .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
  .channel_data_ready, .conversion_consumed, .status_reset_clear_ack,
  .sample_in, .sample_word, .sample_bits, .status_reset_flag, .config_out,
  .reg_check_active, .input_check_active, .conversion_ready_pin_out,
  .conversion_ready_pin_oe);

// ==== host_model.sv ====
// Host controller model: register port master and ready release
`timescale 1ns/10ps
module host_model
(
  input  wire logic        clk,
  input  wire logic [15:0] reg_rdata,
  output logic      [7:0]  reg_addr,
  output logic      [15:0] reg_wdata,
  output logic             reg_write,
  output logic             reg_read,
  output logic             conversion_consumed
);
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_write = 1'b0;
    reg_read = 1'b0;
    conversion_consumed = 1'b0;
  end
  // Released lines show the inverse, so stale values are never reused
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    reg_addr <= ~a;
    #1 d = reg_rdata;
  endtask
  task automatic consume();
    @(posedge clk);
    conversion_consumed <= 1'b1;
    @(posedge clk);
    conversion_consumed <= 1'b0;
    #1;
  endtask
endmodule

// ==== tb_top.sv ====
// Self-checking bench for the mode and clock configuration registers
`timescale 1ns/10ps
module tb_top import adc_cfg_pkg::*;;
  localparam int PULSE = 3;
  localparam logic [7:0] MA = OPERATING_MODE_CONFIG_ADDR;
  localparam logic [7:0] CA = CLOCK_AND_CHANNEL_CONFIG_ADDR;
  logic        clk, sys_rst, reg_write, reg_read, conversion_consumed;
  logic        status_reset_flag, reg_check_active, input_check_active;
  logic        conversion_ready_pin_out, conversion_ready_pin_oe;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d, w;
  logic [5:0]  channel_data_ready, sample_bits;
  logic [23:0] sample_in, s;
  logic [31:0] sample_word;
  config_out_t config_out;
  logic [15:0] rmode [4] = '{16'h0000, 16'h0004, 16'h000A, 16'h000C};
  int          miscompares, num_checks, n;
  int          seed = 15381;

  adc_mode_clock_config_regs #(.PULSE_CYCLES(PULSE)) DUT (.clk, .sys_rst,
    .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .channel_data_ready, .conversion_consumed, .status_reset_clear_ack(1'b0),
    .sample_in, .sample_word, .sample_bits, .status_reset_flag, .config_out,
    .reg_check_active, .input_check_active, .conversion_ready_pin_out,
    .conversion_ready_pin_oe);
  host_model host (.clk, .reg_rdata, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .conversion_consumed);

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [31:0] fmt32(logic [1:0] wl, logic [23:0] v);
    case (wl)
      2'h0:    return {16'h0000, v[23:8]};
      2'h1:    return {8'h00, v};
      2'h2:    return {v, 8'h00};
      default: return {{8{v[23]}}, v};
    endcase
  endfunction
  task automatic pulse_ch(logic [5:0] m);
    @(posedge clk);
    channel_data_ready <= m;
    @(posedge clk);
    channel_data_ready <= 6'h00;
    #1;
  endtask
  task automatic finish_test();
    if (miscompares == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    #500000 miscompares++;
    finish_test();
  end

  initial
  begin
    sys_rst = 1'b1;
    channel_data_ready = 6'h00;
    sample_in = 24'h000000;
    // Second pass re-enters reset in mid-run
    repeat (2)
    begin
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      #1 chk("flag", 1'b1, status_reset_flag);
      chk("pin", 2'h3, {conversion_ready_pin_out, conversion_ready_pin_oe});
      chk("timeout", 1'b1, config_out.timeout_enable);
      host.rd(MA, d);
      chk("mode", OPERATING_MODE_CONFIG_RESET, d);
      host.rd(CA, d);
      chk("clock", CLOCK_AND_CHANNEL_CONFIG_RESET, d);
      host.wr(MA, 16'hFFFF);
      host.rd(MA, d);
      chk("mode mask", 16'h3F1F, d);
      host.wr(MA, 16'h0000);
      chk("flag clr", 1'b0, status_reset_flag);
      host.wr(MA, 16'h0400);
      host.rd(MA, d);
      chk("no set", 16'h0000, d);
      chk("flag kept", 1'b0, status_reset_flag);
      host.wr(8'h05, 16'hFFFF);
      host.rd(8'h05, d);
      chk("unmapped", 16'h0000, d);
      repeat (16)
      begin
        w = 16'($random(seed)) & 16'h3B1F;
        host.wr(MA, w);
        host.rd(MA, d);
        chk("mode rb", w, d);
        chk("checks", w[13:10], {reg_check_active,
          input_check_active, config_out.poly_ansi,
          config_out.reset_flag});
        chk("tmo", w[4], config_out.timeout_enable);
        chk("bits", w[9] ? 6'h20 : w[8] ? 6'h18 : 6'h10, sample_bits);
        chk("idle", {1'b1, ~w[1]}, {conversion_ready_pin_out,
          conversion_ready_pin_oe});
        s = 24'($random(seed));
        @(posedge clk);
        sample_in <= s;
        @(posedge clk);
        #1 chk("word", fmt32(w[9:8], s), sample_word);
        w = 16'($random(seed)) & 16'h3FDF;
        host.wr(CA, w);
        host.rd(CA, d);
        chk("clock rb", w, d);
        chk("chan", w[13:8], config_out.channel_conv_enable);
        chk("osc", w[7:6], {config_out.oscillator_disable,
          config_out.external_vref_enable});
        chk("osr", 15'h0080 << w[4:2], config_out.oversample_ratio);
        chk("pwr", w[1:0], config_out.power_mode_select);
      end
      host.wr(CA, 16'h3F0E);
      foreach (rmode[i])
      begin
        host.wr(MA, rmode[i]);
        pulse_ch(6'h01);
        chk("first", rmode[i][3:2] == 2'h0, conversion_ready_pin_out);
        pulse_ch(6'h3E);
        repeat (3) @(posedge clk);
        #1 chk("held", 2'h1, {conversion_ready_pin_out,
          conversion_ready_pin_oe});
        host.consume();
        @(posedge clk);
        #1 chk("free", {1'b1, ~rmode[i][1]}, {conversion_ready_pin_out,
          conversion_ready_pin_oe});
      end
      host.wr(MA, 16'h0005);
      pulse_ch(6'h04);
      n = 0;
      while (conversion_ready_pin_out === 1'b0 && n < 20)
      begin
        n++;
        @(posedge clk);
        #1;
      end
      chk("pulse", PULSE, n);
      // Leading source: only the first channel of a round is signalled
      host.wr(MA, 16'h0009);
      pulse_ch(6'h3B);
      chk("lead rest", 1'b1, conversion_ready_pin_out);
      pulse_ch(6'h02);
      chk("lead first", 1'b0, conversion_ready_pin_out);
      repeat (3) @(posedge clk);
      pulse_ch(6'h01);
      chk("lead next", 1'b1, conversion_ready_pin_out);
    end
    finish_test();
  end
endmodule
